/* erase_host.sv */
// Host end: sends erase commands and waits for the device to finish
`timescale 1ns/1ps
module erase_host (
  // Link
  erase_link_if.host link,
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        binary_mode,
  // Command request
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [12:0] cmd_page,
  // Device state
  output logic             dev_ready
);

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_SHIFT = 4'b0010,
    HS_GUARD = 4'b0100,
    HS_WAIT  = 4'b1000
  } host_state_e;

  host_state_e state_reg;
  logic [31:0] frame_reg;
  logic [1:0]  ph_reg;
  logic [4:0]  cnt_reg;
  logic        sck_reg;
  logic        cs_n_reg;
  logic        rdy_sync1_reg;
  logic        rdy_sync2_reg;

  // ------------------------------------------------------------------
  // Ready pin synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdy_sync1_reg <= 1'b1;
      rdy_sync2_reg <= 1'b1;
    end else begin
      rdy_sync1_reg <= link.rdy_busy_n;
      rdy_sync2_reg <= rdy_sync1_reg;
    end
  end

  assign dev_ready = rdy_sync2_reg;
  assign cmd_ready = state_reg == HS_IDLE;

  // ------------------------------------------------------------------
  // Frame sender, link clock divided by four
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= HS_IDLE;
      frame_reg <= 32'h00000000;
      ph_reg    <= 2'h0;
      cnt_reg   <= 5'h00;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
    end else begin
      case (state_reg)
        HS_IDLE: begin
          sck_reg <= 1'b0;
          if (cmd_valid) begin
            frame_reg <= {erase_pkg::opcode_of(erase_pkg::erase_kind_e'(cmd_kind)),
                          erase_pkg::addr_from_page(cmd_page, binary_mode)};
            ph_reg    <= 2'h0;
            cnt_reg   <= 5'h00;
            cs_n_reg  <= 1'b0;
            state_reg <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          ph_reg  <= ph_reg + 2'h1;
          sck_reg <= ph_reg == 2'h1 || ph_reg == 2'h2;
          if (ph_reg == 2'h3) begin
            frame_reg <= {frame_reg[30:0], 1'b0};
            cnt_reg   <= cnt_reg + 5'h01;
            if (cnt_reg == erase_pkg::LAST_BIT_IDX[4:0]) begin
              cs_n_reg  <= 1'b1;
              cnt_reg   <= 5'h00;
              state_reg <= HS_GUARD;
            end
          end
        end
        HS_GUARD: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == erase_pkg::GUARD_LAST) begin
            state_reg <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (rdy_sync2_reg) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.sck  = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.si   = frame_reg[31];

endmodule

/* erase_link_if.sv */
// Serial erase command link between host and flash device
`timescale 1ns/1ps
interface erase_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic rdy_busy_n;

  modport host (
    output sck,
    output cs_n,
    output si,
    input  rdy_busy_n
  );

  modport device (
    input  sck,
    input  cs_n,
    input  si,
    output rdy_busy_n
  );
endinterface

/* erase_link_monitor.sv */
// Protocol assertions on the erase command link
`timescale 1ns/1ps
module erase_link_monitor #(
  parameter int PAGE_ERASE_CYCLES   = 300,
  parameter int SECTOR_ERASE_CYCLES = 500
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rdy_busy_n
);
  localparam int BUSY_MAX = SECTOR_ERASE_CYCLES + 16;
  localparam int BUSY_MIN = PAGE_ERASE_CYCLES - 16;

  logic        sck_q;
  logic [5:0]  bit_cnt;
  logic [15:0] busy_cnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    sck_q <= sck;
  end

  always_ff @(posedge core_clk) begin
    if (rst || cs_n) begin
      bit_cnt <= 6'h00;
    end else if (sck && !sck_q) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || rdy_busy_n) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence frame_end_s;
    $rose(cs_n);
  endsequence

  sequence busy_start_s;
    ##[3:5] !rdy_busy_n;
  endsequence

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("sck moved outside a frame");
  si_hold_a: assert property ($rose(sck) |=> $stable(si))
    else $error("si changed while sck high");
  frame_bits_a: assert property (frame_end_s |-> bit_cnt == 6'h20)
    else $error("frame did not carry 32 bits");
  busy_start_a: assert property (frame_end_s |-> busy_start_s)
    else $error("busy not shown after frame end");
  busy_max_a: assert property ($fell(rdy_busy_n) |-> ##[1:BUSY_MAX] rdy_busy_n)
    else $error("erase overran its time");
  busy_min_a: assert property ($rose(rdy_busy_n) |-> busy_cnt >= BUSY_MIN)
    else $error("erase ended too early");
  cs_gap_a: assert property (frame_end_s |=> cs_n [*8])
    else $error("chip select gap too short");
  no_cmd_busy_a: assert property ($fell(cs_n) |-> rdy_busy_n)
    else $error("frame started while busy");
endmodule

/* erase_pkg.sv */
// Shared constants, types and address helpers for the erase command link
package erase_pkg;

  // ------------------------------------------------------------------
  // Command opcodes and frame layout
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
  localparam int         CMD_BITS        = 32;
  localparam int         ADDR_BITS       = 24;
  localparam int         PAGE_BITS       = 13;
  localparam int         PAGES           = 8192;
  localparam logic [5:0] LAST_BIT_IDX    = 6'h1F;
  localparam logic [5:0] OVER_BIT_IDX    = 6'h20;
  localparam logic [5:0] CNT_SAT         = 6'h21;

  // ------------------------------------------------------------------
  // Erase region geometry
  // ------------------------------------------------------------------
  localparam logic [12:0] SECTOR0A_FIRST = 13'h0000;
  localparam logic [12:0] SECTOR0A_LAST  = 13'h0007;
  localparam logic [12:0] SECTOR0B_FIRST = 13'h0008;
  localparam logic [12:0] SECTOR0B_LAST  = 13'h00FF;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS             = 40;
  localparam int PAGE_ERASE_TIME_MAX_US    = 1000;
  localparam int BLOCK_ERASE_TIME_MAX_US   = 2000;
  localparam int SECTOR_ERASE_TIME_MAX_US  = 5000;
  localparam int PAGE_ERASE_CYCLES   = PAGE_ERASE_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_CYCLES  = BLOCK_ERASE_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int HOST_GUARD_CYCLES   = 16;
  localparam logic [4:0] GUARD_LAST  = 5'h0F;

  // ------------------------------------------------------------------
  // Reset values and status layout
  // ------------------------------------------------------------------
  localparam int         STATUS_READY_BIT = 7;
  localparam logic [7:0] STATUS_RESET     = 8'h80;

  typedef enum logic [1:0] {
    KIND_PAGE   = 2'h0,
    KIND_BLOCK  = 2'h1,
    KIND_SECTOR = 2'h2
  } erase_kind_e;

  // Page number from the three address bytes
  function automatic logic [12:0] page_from_addr(input logic [23:0] addr,
                                                 input logic binary);
    page_from_addr = binary ? addr[22:10] : addr[23:11];
  endfunction

  // Three address bytes from a page number, don't-care bits zero
  function automatic logic [23:0] addr_from_page(input logic [12:0] page,
                                                 input logic binary);
    addr_from_page = binary ? {1'b0, page, 10'h000} : {page, 11'h000};
  endfunction

  function automatic logic [7:0] opcode_of(input erase_kind_e kind);
    case (kind)
      KIND_PAGE:   opcode_of = OP_PAGE_ERASE;
      KIND_BLOCK:  opcode_of = OP_BLOCK_ERASE;
      default:     opcode_of = OP_SECTOR_ERASE;
    endcase
  endfunction

endpackage

/* erase_timer.sv */
// Self-timed countdown for erase duration
`timescale 1ns/1ps
module erase_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  input  wire logic [31:0] load,
  output logic             expired
);

  logic [31:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 32'h00000000;
    end else if (start) begin
      cnt_reg <= load;
    end else if (cnt_reg != 32'h00000000) begin
      cnt_reg <= cnt_reg - 32'h00000001;
    end
  end

  assign expired = (cnt_reg == 32'h00000000);

endmodule

/* flash_erase_command_decoder_tb_top.sv */
// Testbench joining host and device ends over the erase link
`timescale 1ns/1ps
module flash_erase_command_decoder_tb_top;
  localparam int PAGE_CYC = 300;
  localparam int SECT_CYC = 500;

  logic        core_clk;
  logic        rst;
  logic        binary_mode;
  logic        cmd_valid;
  logic [1:0]  cmd_kind;
  logic [12:0] cmd_page;
  logic [12:0] query_page;
  wire logic        cmd_ready;
  wire logic        dev_ready;
  wire logic        query_erased;
  wire logic        erase_done;
  wire logic        cmd_rejected;
  wire logic [7:0]  status_reg;
  wire logic [1:0]  erase_kind;
  wire logic [12:0] erase_first;
  wire logic [12:0] erase_last;
  int          fails;
  int          num_checks;
  int          sck_rises;
  int          rejects;
  logic [31:0] frame_seen;

  erase_link_if link_bus();
  erase_host i_erase_host (.link(link_bus.host), .core_clk(core_clk), .rst(rst),
    .binary_mode(binary_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_page(cmd_page), .dev_ready(dev_ready));
  flash_erase_device #(.PAGE_ERASE_CYCLES(PAGE_CYC), .BLOCK_ERASE_CYCLES(400),
    .SECTOR_ERASE_CYCLES(SECT_CYC)) i_flash_erase_device (.link(link_bus.device),
    .core_clk(core_clk), .rst(rst), .binary_mode(binary_mode), .query_page(query_page),
    .query_erased(query_erased), .status_reg(status_reg), .erase_done(erase_done),
    .cmd_rejected(cmd_rejected), .erase_kind(erase_kind), .erase_first(erase_first),
    .erase_last(erase_last));
  erase_link_monitor #(.PAGE_ERASE_CYCLES(PAGE_CYC), .SECTOR_ERASE_CYCLES(SECT_CYC))
    i_erase_link_monitor (.core_clk(core_clk), .rst(rst), .sck(link_bus.sck),
    .cs_n(link_bus.cs_n), .si(link_bus.si), .rdy_busy_n(link_bus.rdy_busy_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Wire-side capture of each frame
  always @(posedge link_bus.sck) begin
    if (link_bus.cs_n === 1'b0) begin
      frame_seen <= {frame_seen[30:0], link_bus.si};
      sck_rises <= sck_rises + 1;
    end
  end

  always @(posedge core_clk) begin
    if (cmd_rejected === 1'b1) rejects <= rejects + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic cond(input int sel);
    if (sel == 0) return cmd_ready === 1'b1;
    if (sel == 1) return link_bus.rdy_busy_n === 1'b0;
    return erase_done === 1'b1;
  endfunction

  task automatic wait_until(input int sel, input string what);
    int n;
    n = 0;
    while (!cond(sel) && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      $display("mismatch %s expected event seen timeout", what);
      report_and_stop();
    end
  endtask

  // One erase through the host, judged at wire, status and erased map
  task automatic do_erase(input logic [1:0] kind, input logic [12:0] page, input logic bm,
                          input logic [12:0] first, input logic [12:0] last,
                          input logic [12:0] outside);
    logic [23:0] addr;
    logic [7:0]  op;
    addr = bm ? {1'b0, page, 10'h000} : {page, 11'h000};
    op = (kind == 2'h0) ? 8'h81 : (kind == 2'h1) ? 8'h50 : 8'h7C;
    wait_until(0, "cmd_ready");
    binary_mode = bm;
    cmd_kind = kind;
    cmd_page = page;
    cmd_valid = 1'b1;
    sck_rises = 0;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    wait_until(1, "busy");
    check("status busy", 32'h00, {24'h0, status_reg});
    check("frame", {op, addr}, frame_seen);
    check("sck rises", 32'h20, sck_rises);
    repeat (2) @(negedge core_clk);
    check("dev_ready busy", 32'h0, {31'h0, dev_ready});
    check("cmd_ready busy", 32'h0, {31'h0, cmd_ready});
    wait_until(2, "erase_done");
    @(negedge core_clk);
    check("status ready", {24'h0, erase_pkg::STATUS_RESET}, {24'h0, status_reg});
    check("kind", {30'h0, kind == 2'h3 ? 2'h2 : kind}, {30'h0, erase_kind});
    check("first", {19'h0, first}, {19'h0, erase_first});
    check("last", {19'h0, last}, {19'h0, erase_last});
    query_page = first;
    repeat (2) @(negedge core_clk);
    check("first erased", 32'h1, {31'h0, query_erased});
    query_page = last;
    repeat (2) @(negedge core_clk);
    check("last erased", 32'h1, {31'h0, query_erased});
    query_page = outside;
    repeat (2) @(negedge core_clk);
    check("outside kept", 32'h0, {31'h0, query_erased});
    check("dev_ready idle", 32'h1, {31'h0, dev_ready});
    check("cmd_ready idle", 32'h1, {31'h0, cmd_ready});
  endtask

  task automatic test_page_erase();
    do_erase(2'h0, 13'h1ABC, 1'b0, 13'h1ABC, 13'h1ABC, 13'h1ABD);
    do_erase(2'h0, 13'h0123, 1'b1, 13'h0123, 13'h0123, 13'h0124);
    $display("test page erase done");
  endtask

  task automatic test_block_erase();
    do_erase(2'h1, 13'h1FFD, 1'b0, 13'h1FF8, 13'h1FFF, 13'h1FF7);
    do_erase(2'h1, 13'h0A5D, 1'b1, 13'h0A58, 13'h0A5F, 13'h0A60);
    $display("test block erase done");
  endtask

  task automatic test_sector_erase();
    do_erase(2'h2, 13'h0005, 1'b0, 13'h0000, 13'h0007, 13'h0008);
    do_erase(2'h2, 13'h0009, 1'b1, 13'h0008, 13'h00FF, 13'h0100);
    do_erase(2'h2, 13'h1F42, 1'b0, 13'h1F00, 13'h1FFF, 13'h1EFF);
    do_erase(2'h3, 13'h0342, 1'b1, 13'h0300, 13'h03FF, 13'h0400);
    check("rejects", 32'h0, rejects);
    $display("test sector erase done");
  endtask

  initial begin
    rst = 1'b1;
    binary_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_page = 13'h0000;
    query_page = 13'h0000;
    fails = 0;
    num_checks = 0;
    sck_rises = 0;
    rejects = 0;
    frame_seen = 32'h0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check("ready after reset", {24'h0, erase_pkg::STATUS_RESET}, {24'h0, status_reg});
    test_page_erase();
    test_block_erase();
    test_sector_erase();
    report_and_stop();
  end
endmodule

/* flash_erase_device.sv */
// Flash device end: erase command decode and self-timed erase
// Function
// - Page erase: 81H, 13 page bits, 11 ignored
// - Binary page erase uses linear_page_bits, 10 ignored
// - Page erase leaves selected page all ones
// - Busy shown in status and ready pin
// - Erase self-timed within its maximum time
// - Block erase: 50H, page bits 12-3
// - Binary block erase: linear bits 22-13
// - Block erase clears eight pages of block
// - Sector erase 7CH, one of 32 sectors
// - Sector 0a/0b standard: page bits 12-3
// - Sectors 1-31 standard: page bits 12-8
// - Binary sector address: one leading ignored bit
// - Zero upper bits: bit 3 picks 0a/0b
// - Sector erase starts on chip select rise
// - Host may pre-erase pages before programming
`timescale 1ns/1ps
module flash_erase_device #(
  parameter int PAGE_ERASE_CYCLES   = erase_pkg::PAGE_ERASE_CYCLES,
  parameter int BLOCK_ERASE_CYCLES  = erase_pkg::BLOCK_ERASE_CYCLES,
  parameter int SECTOR_ERASE_CYCLES = erase_pkg::SECTOR_ERASE_CYCLES
) (
  // Link
  erase_link_if.device link,
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        binary_mode,
  // Erased-page query
  input  wire logic [12:0] query_page,
  output logic             query_erased,
  // Status
  output logic [7:0]       status_reg,
  output logic             erase_done,
  output logic             cmd_rejected,
  output logic [1:0]       erase_kind,
  output logic [12:0]      erase_first,
  output logic [12:0]      erase_last
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WALK = 3'b010,
    ST_WAIT = 3'b100
  } dev_state_e;

  // ------------------------------------------------------------------
  // Link clock domain: frame capture
  // ------------------------------------------------------------------
  logic [31:0] shift_reg;
  logic [5:0]  bit_cnt_reg;
  logic        frame_tgl_reg = 1'b0;
  logic        over_reg      = 1'b0;
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= 6'h00;
    end else if (bit_cnt_reg != erase_pkg::CNT_SAT) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end
  always_ff @(posedge link.sck) begin
    shift_reg <= {shift_reg[30:0], link.si};
  end
  always_ff @(posedge link.sck) begin
    if (!link.cs_n && bit_cnt_reg == erase_pkg::LAST_BIT_IDX) begin
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end
  always_ff @(posedge link.sck) begin
    if (bit_cnt_reg == 6'h00) begin
      over_reg <= 1'b0;
    end else if (bit_cnt_reg == erase_pkg::OVER_BIT_IDX) begin
      over_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Crossing into the core domain
  // ------------------------------------------------------------------
  logic cs_sync1_reg;
  logic cs_sync2_reg;
  logic cs_prev_reg;
  logic tgl_sync1_reg;
  logic tgl_sync2_reg;
  logic last_tgl_reg;
  logic cs_rise;
  logic frame_new;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_sync1_reg  <= 1'b1;
      cs_sync2_reg  <= 1'b1;
      cs_prev_reg   <= 1'b1;
      tgl_sync1_reg <= 1'b0;
      tgl_sync2_reg <= 1'b0;
    end else begin
      cs_sync1_reg  <= link.cs_n;
      cs_sync2_reg  <= cs_sync1_reg;
      cs_prev_reg   <= cs_sync2_reg;
      tgl_sync1_reg <= frame_tgl_reg;
      tgl_sync2_reg <= tgl_sync1_reg;
    end
  end
  assign cs_rise   = cs_sync2_reg && !cs_prev_reg;
  assign frame_new = tgl_sync2_reg != last_tgl_reg;

  // Frame word is stable while chip select stays high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_tgl_reg <= tgl_sync2_reg;
    end else if (cs_rise) begin
      last_tgl_reg <= tgl_sync2_reg;
    end
  end

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  logic [7:0]  opcode;
  logic [12:0] page;
  logic        op_known;
  logic [1:0]  kind_next;
  logic [12:0] first_next;
  logic [12:0] last_next;
  logic [31:0] load_next;
  assign opcode = shift_reg[31:24];
  assign page   = erase_pkg::page_from_addr(shift_reg[23:0], binary_mode);

  always_comb begin
    op_known   = 1'b1;
    kind_next  = erase_pkg::KIND_PAGE;
    first_next = page;
    last_next  = page;
    load_next  = 32'(PAGE_ERASE_CYCLES);
    case (opcode)
      erase_pkg::OP_PAGE_ERASE: kind_next = erase_pkg::KIND_PAGE;
      erase_pkg::OP_BLOCK_ERASE: begin
        kind_next  = erase_pkg::KIND_BLOCK;
        first_next = {page[12:3], 3'h0};
        last_next  = {page[12:3], 3'h7};
        load_next  = 32'(BLOCK_ERASE_CYCLES);
      end
      erase_pkg::OP_SECTOR_ERASE: begin
        kind_next = erase_pkg::KIND_SECTOR;
        load_next = 32'(SECTOR_ERASE_CYCLES);
        if (page[12:8] == 5'h00) begin
          first_next = page[3] ? erase_pkg::SECTOR0B_FIRST : erase_pkg::SECTOR0A_FIRST;
          last_next  = page[3] ? erase_pkg::SECTOR0B_LAST : erase_pkg::SECTOR0A_LAST;
        end else begin
          first_next = {page[12:8], 8'h00};
          last_next  = {page[12:8], 8'hFF};
        end
      end
      default: op_known = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Erase sequencer
  // ------------------------------------------------------------------
  dev_state_e  state_reg;
  logic [12:0] walk_reg;
  logic        accept;
  logic        frame_done;
  logic        timer_expired;
  logic        finish;
  assign frame_done = cs_rise && frame_new && !over_reg;
  assign accept     = frame_done && op_known && state_reg == ST_IDLE;
  assign finish     = state_reg == ST_WAIT && timer_expired;

  erase_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (accept),
    .load     (load_next),
    .expired  (timer_expired)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= ST_WALK;
          end
        end
        ST_WALK: begin
          if (walk_reg == erase_last) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer_expired) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      erase_kind  <= erase_pkg::KIND_PAGE;
      erase_first <= 13'h0000;
      erase_last  <= 13'h0000;
    end else if (accept) begin
      erase_kind  <= kind_next;
      erase_first <= first_next;
      erase_last  <= last_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      walk_reg <= 13'h0000;
    end else if (accept) begin
      walk_reg <= first_next;
    end else if (state_reg == ST_WALK && walk_reg != erase_last) begin
      walk_reg <= walk_reg + 13'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Array erased-state map
  // ------------------------------------------------------------------
  logic [erase_pkg::PAGES-1:0] erased_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      erased_reg <= '0;
    end else if (state_reg == ST_WALK) begin
      erased_reg[walk_reg] <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      query_erased <= 1'b0;
    end else begin
      query_erased <= erased_reg[query_page];
    end
  end

  // ------------------------------------------------------------------
  // Busy reporting and events
  // ------------------------------------------------------------------
  logic ready_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ready_reg <= 1'b1;
    end else if (accept) begin
      ready_reg <= 1'b0;
    end else if (finish) begin
      ready_reg <= 1'b1;
    end
  end
  assign link.rdy_busy_n = ready_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg   <= erase_pkg::STATUS_RESET;
      erase_done   <= 1'b0;
      cmd_rejected <= 1'b0;
    end else begin
      status_reg   <= 8'h00;
      status_reg[erase_pkg::STATUS_READY_BIT] <= !accept && (ready_reg || finish);
      erase_done   <= finish;
      cmd_rejected <= frame_done && !accept;
    end
  end

endmodule
